// [shared/lcss_pkg.sv]
// Notes on behaviour
// - With a line chosen as source, its level at each frame trigger decides advance.
// - Sets step only upward by index, at most one step per frame trigger.
// - Enabling the sequencer copies set 0 into the active set before use.
// - With the invert bit clear, a low sampled line keeps the current set for that frame.
// - With the invert bit clear, a high sampled line loads the next set into the active set for that frame.
// - Valid indices run from zero to total count minus one.
// - With the invert bit clear, a high line at the highest index wraps back to set 0.
// - Waiting-for-trigger status drops briefly whenever an input line changes level.
// - Triggers arriving while that status is low are discarded entirely.
// - Disable takes effect only after the current frame's exposure and readout end.
// - On disable the active parameters return to values saved at enable.
// - The second line as source behaves exactly like the first, using its level.
// - Total set count per cycle is at most 64.
package lcss_pkg;
   localparam int unsigned LCSS_MAX_SETS = 64;
   localparam int unsigned LCSS_CLK_HZ = 40_000_000;
   localparam int unsigned LCSS_SETTLE_NS = 1000;
   localparam int unsigned LCSS_SETTLE_CYC = (LCSS_SETTLE_NS * (LCSS_CLK_HZ / 1_000_000)) / 1000;
   localparam logic [7:0] LCSS_SETTLE_CYC8 = 8'(LCSS_SETTLE_CYC);
   localparam logic [11:0] LCSS_ADDR_CTRL = 12'h000;
   localparam logic [11:0] LCSS_ADDR_TOTAL = 12'h004;
   localparam logic [11:0] LCSS_ADDR_STATUS = 12'h008;
   localparam logic [11:0] LCSS_ADDR_SAVED = 12'h00C;
   localparam logic [11:0] LCSS_ADDR_SET_BASE = 12'h100;
   localparam logic [11:0] LCSS_ADDR_SET_END = 12'h1FC;
   localparam int unsigned LCSS_CTRL_EN_BIT = 0;
   localparam int unsigned LCSS_CTRL_SRC_BIT = 1;
   localparam int unsigned LCSS_CTRL_INV_BIT = 2;
   localparam logic [6:0] LCSS_TOTAL_RST = 7'h06;
   localparam logic [1:0] LCSS_RESP_OKAY = 2'h0;
   localparam logic [1:0] LCSS_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      LCSS_IDLE = 2'b00,
      LCSS_RUN = 2'b01,
      LCSS_DRAIN = 2'b10
   } lcss_state_t;
endpackage

// [design/lcss_top.sv]
`timescale 1ns/1ps
module lcss_top import lcss_pkg::*; #(
   parameter int unsigned PARAM_W = 32,
   parameter int unsigned SETS = LCSS_MAX_SETS
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic line1_in,
   input wire logic line2_in,
   input wire logic frame_trig_in,
   input wire logic frame_done_in,
   input wire logic [11:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [11:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic waiting_out,
   output logic frame_start_out,
   output logic [5:0] cur_index_out,
   output logic [PARAM_W-1:0] active_param_out,
   output logic seq_active_out
);
   // Refuses set counts and widths that the index, memory and bus word cannot serve.
   if (SETS < 1 || SETS > LCSS_MAX_SETS
      || PARAM_W < 1 || PARAM_W > 32) begin : g_bad_params
      $error("lcss_top: unsupported parameter values");
   end

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   logic [2:0] l1_sync_reg, l2_sync_reg, trig_sync_reg, done_sync_reg;
   logic l1_reg, l2_reg, trig_reg, done_reg;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         l1_sync_reg <= 3'h0;
         l2_sync_reg <= 3'h0;
         trig_sync_reg <= 3'h0;
         done_sync_reg <= 3'h0;
      end else if (clk_en_in) begin
         l1_sync_reg <= {l1_sync_reg[1:0], line1_in};
         l2_sync_reg <= {l2_sync_reg[1:0], line2_in};
         trig_sync_reg <= {trig_sync_reg[1:0], frame_trig_in};
         done_sync_reg <= {done_sync_reg[1:0], frame_done_in};
      end
   end

   // A level is accepted once the second and third stages agree.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         l1_reg <= 1'b0;
         l2_reg <= 1'b0;
         trig_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (l1_sync_reg[1] == l1_sync_reg[2]) l1_reg <= l1_sync_reg[2];
         if (l2_sync_reg[1] == l2_sync_reg[2]) l2_reg <= l2_sync_reg[2];
         if (trig_sync_reg[1] == trig_sync_reg[2]) trig_reg <= trig_sync_reg[2];
         if (done_sync_reg[1] == done_sync_reg[2]) done_reg <= done_sync_reg[2];
      end
   end

   logic l1_q_reg, l2_q_reg, trig_q_reg, done_q_reg;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         l1_q_reg <= 1'b0;
         l2_q_reg <= 1'b0;
         trig_q_reg <= 1'b0;
         done_q_reg <= 1'b0;
      end else if (clk_en_in) begin
         l1_q_reg <= l1_reg;
         l2_q_reg <= l2_reg;
         trig_q_reg <= trig_reg;
         done_q_reg <= done_reg;
      end
   end

   logic line_change, trig_rise, done_rise;
   assign line_change = (l1_reg != l1_q_reg) || (l2_reg != l2_q_reg);
   assign trig_rise = trig_reg && !trig_q_reg;
   assign done_rise = done_reg && !done_q_reg;

   // -----------------------------------------------------------------
   // Waiting status and trigger acceptance
   // -----------------------------------------------------------------
   logic [7:0] settle_reg;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         settle_reg <= 8'h00;
      end else if (clk_en_in) begin
         if (line_change) begin
            settle_reg <= LCSS_SETTLE_CYC8;
         end else if (settle_reg != 8'h00) begin
            settle_reg <= settle_reg - 8'h01;
         end
      end
   end

   logic waiting, trig_ok;
   assign waiting = (settle_reg == 8'h00) && !line_change;
   assign trig_ok = trig_rise && waiting;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         waiting_out <= 1'b0;
         frame_start_out <= 1'b0;
      end else if (clk_en_in) begin
         waiting_out <= waiting;
         frame_start_out <= trig_ok;
      end
   end

   // -----------------------------------------------------------------
   // Registers written by software
   // -----------------------------------------------------------------
   logic en_reg, src_reg, inv_reg;
   logic [6:0] total_reg;
   logic [PARAM_W-1:0] set_mem [SETS];
   logic [PARAM_W-1:0] saved_reg;
   logic [PARAM_W-1:0] base_param_reg;

   logic [11:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic aw_have_reg, w_have_reg;
   logic wr_fire, wr_set_hit;
   logic [5:0] wr_idx;
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid_out;
   assign wr_idx = awaddr_reg[7:2];
   assign wr_set_hit = (awaddr_reg >= LCSS_ADDR_SET_BASE) && (awaddr_reg <= LCSS_ADDR_SET_END)
      && (32'(wr_idx) < SETS);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 12'h000;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= LCSS_RESP_OKAY;
      end else if (clk_en_in) begin
         // No new address or data is taken while a write answer is still pending.
         s_axi_awready_out <= !aw_have_reg && !s_axi_awready_out && !s_axi_bvalid_out;
         s_axi_wready_out <= !w_have_reg && !s_axi_wready_out && !s_axi_bvalid_out;
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_in;
            wstrb_reg <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (awaddr_reg == LCSS_ADDR_CTRL || awaddr_reg == LCSS_ADDR_TOTAL
               || awaddr_reg == LCSS_ADDR_SAVED || wr_set_hit) ? LCSS_RESP_OKAY
               : LCSS_RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         en_reg <= 1'b0;
         src_reg <= 1'b0;
         inv_reg <= 1'b0;
         total_reg <= LCSS_TOTAL_RST;
         base_param_reg <= '0;
      end else if (clk_en_in && wr_fire && wstrb_reg[0]) begin
         if (awaddr_reg == LCSS_ADDR_CTRL) begin
            en_reg <= wdata_reg[LCSS_CTRL_EN_BIT];
            src_reg <= wdata_reg[LCSS_CTRL_SRC_BIT];
            inv_reg <= wdata_reg[LCSS_CTRL_INV_BIT];
         end
         if (awaddr_reg == LCSS_ADDR_TOTAL && wdata_reg[6:0] != 7'h00
            && 32'(wdata_reg[6:0]) <= SETS) begin
            total_reg <= wdata_reg[6:0];
         end
         if (awaddr_reg == LCSS_ADDR_SAVED) begin
            base_param_reg <= wdata_reg[PARAM_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (clk_en_in && wr_fire && wr_set_hit && wstrb_reg[0]) begin
         set_mem[wr_idx] <= wdata_reg[PARAM_W-1:0];
      end
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   lcss_state_t state_reg;
   logic [5:0] idx_reg;
   logic [5:0] idx_next;
   logic ctl_level;
   logic frame_busy_reg;
   assign ctl_level = (src_reg ? l2_reg : l1_reg) ^ inv_reg;
   assign idx_next = (7'(idx_reg) + 7'h01 >= total_reg) ? 6'h00 : idx_reg + 6'h01;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         frame_busy_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (trig_ok) frame_busy_reg <= 1'b1;
         else if (done_rise) frame_busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg <= LCSS_IDLE;
         idx_reg <= 6'h00;
         saved_reg <= '0;
         active_param_out <= '0;
      end else if (clk_en_in) begin
         unique case (state_reg)
            LCSS_IDLE: begin
               active_param_out <= base_param_reg;
               if (en_reg) begin
                  saved_reg <= base_param_reg;
                  idx_reg <= 6'h00;
                  active_param_out <= set_mem[0];
                  state_reg <= LCSS_RUN;
               end
            end
            LCSS_RUN: begin
               if (trig_ok && ctl_level) begin
                  idx_reg <= idx_next;
                  active_param_out <= set_mem[idx_next];
               end
               if (!en_reg) begin
                  state_reg <= (frame_busy_reg || trig_ok) ? LCSS_DRAIN : LCSS_IDLE;
                  if (!(frame_busy_reg || trig_ok)) active_param_out <= saved_reg;
               end
            end
            LCSS_DRAIN: begin
               if (!frame_busy_reg) begin
                  active_param_out <= saved_reg;
                  state_reg <= LCSS_IDLE;
               end
            end
            default: state_reg <= LCSS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cur_index_out <= 6'h00;
         seq_active_out <= 1'b0;
      end else if (clk_en_in) begin
         cur_index_out <= idx_reg;
         seq_active_out <= (state_reg != LCSS_IDLE);
      end
   end

   // -----------------------------------------------------------------
   // Read channel
   // -----------------------------------------------------------------
   logic [5:0] rd_idx;
   assign rd_idx = s_axi_araddr_in[7:2];
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= LCSS_RESP_OKAY;
      end else if (clk_en_in) begin
         s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= LCSS_RESP_OKAY;
            s_axi_rdata_out <= 32'h0000_0000;
            if (s_axi_araddr_in == LCSS_ADDR_CTRL) begin
               s_axi_rdata_out <= {29'h0, inv_reg, src_reg, en_reg};
            end else if (s_axi_araddr_in == LCSS_ADDR_TOTAL) begin
               s_axi_rdata_out <= {25'h0, total_reg};
            end else if (s_axi_araddr_in == LCSS_ADDR_STATUS) begin
               s_axi_rdata_out <= {20'h0, 2'(state_reg), l2_reg, l1_reg, waiting,
                  frame_busy_reg, idx_reg};
            end else if (s_axi_araddr_in == LCSS_ADDR_SAVED) begin
               s_axi_rdata_out <= 32'(base_param_reg);
            end else if (s_axi_araddr_in >= LCSS_ADDR_SET_BASE
               && s_axi_araddr_in <= LCSS_ADDR_SET_END && 32'(rd_idx) < SETS) begin
               s_axi_rdata_out <= 32'(set_mem[rd_idx]);
            end else begin
               s_axi_rresp_out <= LCSS_RESP_SLVERR;
            end
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end
endmodule // lcss_top

// [test/lcss_checker.sv]
`timescale 1ns/1ps
module lcss_checker (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic line1_in,
   input wire logic line2_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic waiting_out,
   input wire logic frame_start_out,
   input wire logic [5:0] cur_index_out,
   input wire logic seq_active_out
);
   default clocking cb @(posedge clk_in); endclocking
   chk_step_ascend: assert property (disable iff (sys_rst_in)
      seq_active_out && $past(seq_active_out) && $changed(cur_index_out) |->
      cur_index_out == $past(cur_index_out) + 6'h01 || cur_index_out == 6'h00)
      else $error("index moved other than one step up or wrap");
   chk_step_trig: assert property (disable iff (sys_rst_in)
      seq_active_out && $past(seq_active_out) && $changed(cur_index_out) |-> ##[0:3]
      (frame_start_out || $past(frame_start_out) || $past(frame_start_out, 2)
      || $past(frame_start_out, 3))) else $error("index moved without a frame start");
   chk_settle_drop: assert property (disable iff (sys_rst_in)
      $changed(line1_in) || $changed(line2_in) |-> ##[1:8] !waiting_out)
      else $error("waiting status stayed up after a line change");
   chk_pulse_once: assert property (disable iff (sys_rst_in)
      frame_start_out |=> !frame_start_out) else $error("frame start longer than one cycle");
   chk_rd_answer: assert property (disable iff (sys_rst_in)
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   chk_rd_release: assert property (disable iff (sys_rst_in)
      s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
      else $error("read answer held after it was taken");
   chk_aw_busy: assert property (disable iff (sys_rst_in)
      s_axi_bvalid_out |-> !s_axi_awready_out) else $error("write taken while answer pending");
   chk_ar_busy: assert property (disable iff (sys_rst_in)
      s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken while answer pending");
endmodule // lcss_checker

bind lcss_top lcss_checker i_lcss_checker (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .line1_in(line1_in), .line2_in(line2_in), .s_axi_awready_out(s_axi_awready_out),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
   .s_axi_rready_in(s_axi_rready_in), .waiting_out(waiting_out),
   .frame_start_out(frame_start_out), .cur_index_out(cur_index_out),
   .seq_active_out(seq_active_out));

// [test/lcss_ctl_model.sv]
`timescale 1ns/1ps
module lcss_ctl_model (
   input wire logic clk_in,
   input wire logic waiting_in,
   output logic line1_out,
   output logic line2_out,
   output logic trig_out,
   output logic done_out
);
   initial begin
      line1_out = 1'b0;
      line2_out = 1'b0;
      trig_out = 1'b0;
      done_out = 1'b0;
   end
   task automatic set_lines(input logic a, input logic b);
      line1_out <= a;
      line2_out <= b;
      repeat (8) @(posedge clk_in);
   endtask
   // A trigger that ignores the waiting status is only sent when obey is clear.
   task automatic frame(input bit obey);
      while (obey && waiting_in !== 1'b1) @(posedge clk_in);
      trig_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      trig_out <= 1'b0;
      repeat (44) @(posedge clk_in);
   endtask
   task automatic finish_frame();
      done_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      done_out <= 1'b0;
      repeat (12) @(posedge clk_in);
   endtask
endmodule // lcss_ctl_model

// [test/test_line_controlled_set_sequencer.sv]
`timescale 1ns/1ps
module test_line_controlled_set_sequencer import lcss_pkg::*;;
   logic clk_in, sys_rst_in, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic bvalid, arready, rvalid, waiting, fs, seq, l1, l2, trig, done;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, param, saved_v, rd;
   logic [1:0] bresp, rresp, resp;
   logic [5:0] idx, exp_idx;
   logic [31:0] set_v [6];
   int error_cnt, tests_run, fs_cnt, fs0;
   lcss_top i_lcss_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
      .line1_in(l1), .line2_in(l2), .frame_trig_in(trig), .frame_done_in(done),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .waiting_out(waiting),
      .frame_start_out(fs), .cur_index_out(idx), .active_param_out(param),
      .seq_active_out(seq));
   lcss_ctl_model i_lcss_ctl_model (.clk_in(clk_in), .waiting_in(waiting), .line1_out(l1),
      .line2_out(l2), .trig_out(trig), .done_out(done));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) if (fs === 1'b1) fs_cnt <= fs_cnt + 1;
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", what, e, g);
         error_cnt++;
      end
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      bit aw_ok;
      bit w_ok;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_ok = 0;
      w_ok = 0;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_in);
         if (awvalid && awready === 1'b1) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clk_in);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic axi_rd(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk_in);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge clk_in);
   endtask
   function automatic logic [5:0] next_idx(input logic [5:0] i, input logic adv);
      if (!adv) return i;
      return (i + 6'h01 >= 6'(LCSS_TOTAL_RST)) ? 6'h00 : i + 6'h01;
   endfunction
   // The first frames force a hold and then a full cycle with wrap before random levels.
   task automatic run_frames(input int n, input bit src, input bit inv);
      logic lv;
      logic other;
      for (int k = 0; k < n; k++) begin
         lv = (k == 0) ? 1'b0 : ((k < 8) ? 1'b1 : 1'($urandom));
         other = 1'($urandom);
         if (src) i_lcss_ctl_model.set_lines(other, lv ^ inv);
         else i_lcss_ctl_model.set_lines(lv ^ inv, other);
         fs0 = fs_cnt;
         i_lcss_ctl_model.frame(1'b1);
         exp_idx = next_idx(exp_idx, lv);
         cmp_word("frames started", 32'(fs0 + 1), 32'(fs_cnt));
         cmp_word("set index", {26'h0, exp_idx}, {26'h0, idx});
         cmp_word("active value", set_v[exp_idx], param);
         i_lcss_ctl_model.finish_frame();
      end
   endtask
   initial begin
      sys_rst_in = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      void'($urandom(90739));
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      axi_rd(LCSS_ADDR_TOTAL);
      cmp_word("total reset", 32'h6, rd);
      axi_wr(LCSS_ADDR_TOTAL, 32'h0);
      axi_wr(LCSS_ADDR_TOTAL, 32'(LCSS_MAX_SETS + 1));
      axi_rd(LCSS_ADDR_TOTAL);
      cmp_word("total kept", 32'h6, rd);
      axi_rd(12'h0F0);
      cmp_word("unmapped resp", 32'(LCSS_RESP_SLVERR), 32'(resp));
      axi_wr(12'h0F0, 32'h0000_0000);
      cmp_word("unmapped write resp", 32'(LCSS_RESP_SLVERR), 32'(resp));
      for (int i = 0; i < 6; i++) begin
         set_v[i] = $urandom;
         axi_wr(LCSS_ADDR_SET_BASE + 12'(4 * i), set_v[i]);
         cmp_word("set write resp", 32'(LCSS_RESP_OKAY), 32'(resp));
      end
      saved_v = $urandom;
      axi_wr(LCSS_ADDR_SAVED, saved_v);
      $display("test registers done");
      axi_wr(LCSS_ADDR_CTRL, 32'h1);
      repeat (4) @(posedge clk_in);
      exp_idx = 6'h00;
      cmp_word("enable index", 32'h0, {26'h0, idx});
      cmp_word("enable value", set_v[0], param);
      axi_rd(LCSS_ADDR_STATUS);
      cmp_word("status after enable", 32'h0000_0480, rd);
      run_frames(14, 1'b0, 1'b0);
      $display("test line one done");
      fs0 = fs_cnt;
      i_lcss_ctl_model.set_lines(~l1, l2);
      i_lcss_ctl_model.frame(1'b0);
      cmp_word("dropped trigger", 32'(fs0), 32'(fs_cnt));
      cmp_word("index after drop", {26'h0, exp_idx}, {26'h0, idx});
      $display("test dropped trigger done");
      axi_wr(LCSS_ADDR_CTRL, 32'h0);
      repeat (4) @(posedge clk_in);
      cmp_word("value restored", saved_v, param);
      axi_wr(LCSS_ADDR_CTRL, 32'h7);
      repeat (4) @(posedge clk_in);
      exp_idx = 6'h00;
      run_frames(10, 1'b1, 1'b1);
      $display("test line two done");
      i_lcss_ctl_model.frame(1'b1);
      axi_wr(LCSS_ADDR_CTRL, 32'h0);
      repeat (4) @(posedge clk_in);
      cmp_word("busy during frame", 32'h1, {31'h0, seq});
      i_lcss_ctl_model.finish_frame();
      cmp_word("busy after frame", 32'h0, {31'h0, seq});
      cmp_word("value after frame", saved_v, param);
      $display("test late disable done");
      end_sim();
   end
   initial begin
      repeat (40000) @(posedge clk_in);
      error_cnt++;
      end_sim();
   end
endmodule // test_line_controlled_set_sequencer
